// *** sfpc_pkg.sv ***
// ==========================================================================
// shared constants and types of the socket force and supply control block
// ==========================================================================
package sfpc_pkg;

    // ======================================================================
    // register map
    // ======================================================================
    localparam int SFPC_ADDR_W = 8;
    localparam logic [7:0] SFPC_OFS_FORCE = 8'h0C;
    localparam logic [7:0] SFPC_OFS_CONTROL = 8'h10;
    localparam logic [7:0] SFPC_OFS_STATUS = 8'h18;

    // force register bit positions
    localparam int SFPC_FB_RETEST = 14;
    localparam int SFPC_FB_VOLT_Y = 13;
    localparam int SFPC_FB_VOLT_X = 12;
    localparam int SFPC_FB_VOLT_3 = 11;
    localparam int SFPC_FB_VOLT_5 = 10;
    localparam int SFPC_FB_INVALID = 9;
    localparam int SFPC_FB_LOST = 8;
    localparam int SFPC_FB_UNREC = 7;
    localparam int SFPC_FB_CARDBUS = 5;
    localparam int SFPC_FB_SIXTEEN = 4;
    localparam int SFPC_FB_POWER = 3;
    localparam int SFPC_FB_DETECT2 = 2;
    localparam int SFPC_FB_DETECT1 = 1;
    localparam int SFPC_FB_STATUS = 0;

    // control register layout
    localparam int SFPC_CB_POLICY = 7;
    localparam int SFPC_CB_VCC_LO = 4;
    localparam int SFPC_CB_VPP_LO = 0;
    localparam logic [31:0] SFPC_CONTROL_RESET = 32'h0000_0400;

    // supply request codes
    localparam logic [2:0] SFPC_SUP_OFF = 3'h0;
    localparam logic [2:0] SFPC_SUP_12V = 3'h1;
    localparam logic [2:0] SFPC_SUP_5V = 3'h2;
    localparam logic [2:0] SFPC_SUP_3V3 = 3'h3;
    localparam logic [2:0] SFPC_SUP_XV = 3'h4;
    localparam logic [2:0] SFPC_SUP_YV = 3'h5;

    // interrogation timing
    localparam int SFPC_PROBE_CNT_W = 16;
    localparam int SFPC_PROBE_CYCLES = 16;

    // ======================================================================
    // types
    // ======================================================================
    // card-side pins, synchronised as one vector
    typedef struct packed {
        logic detect_two;
        logic detect_one;
        logic status_change;
        logic sense_cardbus;
        logic sense_sixteen;
        logic sense_unrec;
        logic [3:0] sense_volt; // y, x, 3 V, 5 V
    } sfpc_pins_t;

    // present-state flags kept by this block
    typedef struct packed {
        logic volt_y_capable_flag;
        logic volt_x_capable_flag;
        logic three_volt_capable_flag;
        logic five_volt_capable_flag;
        logic invalid_supply_request_flag;
        logic lost_data_flag;
        logic unrecognised_card_flag;
        logic cardbus_type_flag;
        logic sixteen_bit_type_flag;
        logic socket_powered_flag;
        logic detect_two_level;
        logic detect_one_level;
        logic status_change_level;
    } sfpc_present_t;

    // values written into the socket event register
    typedef struct packed {
        logic power_event_flag;
        logic detect_two_event_flag;
        logic detect_one_event_flag;
        logic status_change_event_flag;
    } sfpc_event_t;

    typedef enum logic [0:0] {
        SFPC_IDLE,
        SFPC_PROBE
    } sfpc_phase_t;

    // complete state of the block
    typedef struct packed {
        sfpc_pins_t sync1;
        sfpc_pins_t sync2;
        sfpc_pins_t sync3;
        sfpc_pins_t live;
        logic card_in;
        sfpc_present_t present;
        logic [2:0] card_supply_request;
        logic [2:0] programming_supply_request;
        logic clock_halt_policy;
        logic auto_power_en;
        sfpc_phase_t phase;
        logic [SFPC_PROBE_CNT_W-1:0] probe_cnt;
        logic [2:0] vcc_apply;
        logic [2:0] vpp_apply;
        logic [31:0] rdata;
    } sfpc_state_t;

endpackage

// *** sfpc_top.sv ***
// Strobed register access was decided locally.
`timescale 1ns/1ns
// Contract
// - card retest write re-interrogates card, refreshes flags, re-enables automatic power control.
// - each force-volt bit write copies its value into matching voltage capability flag.
// - writing one to any force-volt bit disables automatic power control until retest; code also re-enables it on bus reset.
// - force invalid-supply write sets invalid supply flag to written value.
// - force lost-data and unrecognised-card writes set those present flags.
// - force cardbus and sixteen-bit writes set the card type flags.
// - force power event writes power event flag; socket powered flag unchanged.
// - force detect writes set detect event flags; live detect levels unchanged.
// - force status-change write sets status event flag; live level unchanged.
// - force register bits 31..15 and 6 read zero.
// - control resets to 0000_0400h; bit 10 reads one; other reserved bits zero.
// - card supply codes: 000 off, 010 5V, 011 3.3V, 100 X.X, 101 Y.Y.
// - programming supply codes: 000 off, 001 12V, 010 5V, 011 3.3V, 100, 101.
// - with cardbus card inserted, apply only voltages the card accepts; code checks this only while automatic power control is on.
// - clock halt policy selects host-clock-run-gated or unconditional card clock stop.
// - supply fields cleared by bus reset only when power events disabled.
// - invalid supply request flag set when software requests an invalid voltage.
// - detect changes during interrogation are not reflected in live detect levels.
module sfpc_top
    import sfpc_pkg::*;
#(
    parameter int PROBE_CYCLES = SFPC_PROBE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic bus_reset,
    input wire logic pme_enable,
    input wire logic [SFPC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire sfpc_pins_t card_pins,
    input wire logic host_clkrun_stopping,
    input wire logic card_idle,
    output logic card_clk_stop_req,
    output sfpc_present_t present_flags,
    output logic event_force_strobe,
    output sfpc_event_t event_force_value,
    output logic [2:0] vcc_apply,
    output logic [2:0] vpp_apply,
    output logic auto_power_en,
    output logic probe_busy
);

    // ======================================================================
    // helpers
    // ======================================================================
    // a request may be applied when its code is legal and, under automatic
    // control with a cardbus card present, the card accepts the voltage
    function automatic logic supply_ok(input logic [2:0] code, input logic is_vpp,
                                       input sfpc_present_t p, input logic auto_en);
        logic legal;
        logic accepted;
        legal = 1'b0;
        accepted = 1'b1;
        case (code)
            SFPC_SUP_OFF: legal = 1'b1;
            SFPC_SUP_12V: legal = is_vpp;
            SFPC_SUP_5V: begin
                legal = 1'b1;
                accepted = p.five_volt_capable_flag;
            end
            SFPC_SUP_3V3: begin
                legal = 1'b1;
                accepted = p.three_volt_capable_flag;
            end
            SFPC_SUP_XV: begin
                legal = 1'b1;
                accepted = p.volt_x_capable_flag;
            end
            SFPC_SUP_YV: begin
                legal = 1'b1;
                accepted = p.volt_y_capable_flag;
            end
            default: legal = 1'b0;
        endcase
        supply_ok = legal && (accepted || !auto_en || !p.cardbus_type_flag);
    endfunction

    // ======================================================================
    // state
    // ======================================================================
    // pins rest at the no-card level, so leaving reset never looks like an insertion
    localparam sfpc_pins_t PINS_IDLE = '{detect_two: 1'b1, detect_one: 1'b1, default: '0};
    localparam sfpc_state_t STATE_RESET = '{
        sync1: PINS_IDLE,
        sync2: PINS_IDLE,
        sync3: PINS_IDLE,
        live: PINS_IDLE,
        phase: SFPC_IDLE,
        card_supply_request: SFPC_SUP_OFF,
        programming_supply_request: SFPC_SUP_OFF,
        vcc_apply: SFPC_SUP_OFF,
        vpp_apply: SFPC_SUP_OFF,
        auto_power_en: 1'b1,
        default: '0
    };
    localparam logic [SFPC_PROBE_CNT_W-1:0] PROBE_LAST = SFPC_PROBE_CNT_W'(PROBE_CYCLES - 1);

    sfpc_state_t state_ff;
    sfpc_state_t nxt_state;
    logic wr_force;
    logic wr_control;
    logic retest;
    logic [3:0] force_volt;
    sfpc_pins_t agree;
    logic card_now;
    logic [31:0] control_word;
    logic [31:0] status_word;

    // bus decode
    assign wr_force = reg_wr && (reg_addr == SFPC_OFS_FORCE);
    assign wr_control = reg_wr && (reg_addr == SFPC_OFS_CONTROL);
    assign retest = wr_force && reg_wdata[SFPC_FB_RETEST];
    assign force_volt = reg_wdata[SFPC_FB_VOLT_Y:SFPC_FB_VOLT_5];

    // a pin change counts once the second and third stages agree
    assign agree = sfpc_pins_t'(~(state_ff.sync2 ^ state_ff.sync3));
    // both detect lines low means a card sits in the socket
    assign card_now = !state_ff.live.detect_one && !state_ff.live.detect_two;

    // readback words; bit 10 of control is a fixed one
    // control readback layout
    always_comb begin
        control_word = SFPC_CONTROL_RESET;
        control_word[SFPC_CB_POLICY] = state_ff.clock_halt_policy;
        control_word[SFPC_CB_VCC_LO +: 3] = state_ff.card_supply_request;
        control_word[SFPC_CB_VPP_LO +: 3] = state_ff.programming_supply_request;
    end

    // status word of applied supplies, phase and present flags
    assign status_word = {8'h00,
                          state_ff.vpp_apply,
                          state_ff.vcc_apply,
                          (state_ff.phase == SFPC_PROBE),
                          state_ff.auto_power_en,
                          3'h0,
                          state_ff.present};

    // ======================================================================
    // next-state logic
    // ======================================================================
    always_comb begin
        nxt_state = state_ff;

        // three-stage pin synchroniser with agreement filter
        nxt_state.sync1 = card_pins;
        nxt_state.sync2 = state_ff.sync1;
        nxt_state.sync3 = state_ff.sync2;
        nxt_state.live = sfpc_pins_t'((state_ff.sync3 & agree) | (state_ff.live & ~agree));
        nxt_state.card_in = card_now;

        // status-change level tracks the pin, except on a bus reset without power events
        nxt_state.present.status_change_level = state_ff.live.status_change;

        // interrogation sequencer
        case (state_ff.phase)
            SFPC_IDLE: begin
                // detect levels follow only when not probing
                nxt_state.present.detect_one_level = state_ff.live.detect_one;
                nxt_state.present.detect_two_level = state_ff.live.detect_two;
                if (retest || (card_now && !state_ff.card_in)) begin
                    nxt_state.phase = SFPC_PROBE;
                    nxt_state.probe_cnt = '0;
                end
            end
            SFPC_PROBE: begin
                if (state_ff.probe_cnt == PROBE_LAST) begin
                    // refresh presence, type and capability flags
                    nxt_state.phase = SFPC_IDLE;
                    nxt_state.present.detect_one_level = state_ff.live.detect_one;
                    nxt_state.present.detect_two_level = state_ff.live.detect_two;
                    nxt_state.present.cardbus_type_flag = state_ff.live.sense_cardbus;
                    nxt_state.present.sixteen_bit_type_flag = state_ff.live.sense_sixteen;
                    nxt_state.present.unrecognised_card_flag = state_ff.live.sense_unrec;
                    {nxt_state.present.volt_y_capable_flag,
                     nxt_state.present.volt_x_capable_flag,
                     nxt_state.present.three_volt_capable_flag,
                     nxt_state.present.five_volt_capable_flag} = state_ff.live.sense_volt;
                end else begin
                    nxt_state.probe_cnt = state_ff.probe_cnt + 1'b1;
                end
            end
            default: nxt_state.phase = SFPC_IDLE;
        endcase

        // force register writes land on the strobe edge
        if (wr_force) begin
            // copy force-volt values into capability flags
            {nxt_state.present.volt_y_capable_flag,
             nxt_state.present.volt_x_capable_flag,
             nxt_state.present.three_volt_capable_flag,
             nxt_state.present.five_volt_capable_flag} = force_volt;
            nxt_state.present.invalid_supply_request_flag = reg_wdata[SFPC_FB_INVALID];
            nxt_state.present.lost_data_flag = reg_wdata[SFPC_FB_LOST];
            nxt_state.present.unrecognised_card_flag = reg_wdata[SFPC_FB_UNREC];
            nxt_state.present.cardbus_type_flag = reg_wdata[SFPC_FB_CARDBUS];
            nxt_state.present.sixteen_bit_type_flag = reg_wdata[SFPC_FB_SIXTEEN];
            // any force-volt one drops automatic control
            if (|force_volt) begin
                nxt_state.auto_power_en = 1'b0;
            end
            // retest restores automatic control, wins over same-write force
            if (retest) begin
                nxt_state.auto_power_en = 1'b1;
            end
        end

        // control register write
        if (wr_control) begin
            nxt_state.clock_halt_policy = reg_wdata[SFPC_CB_POLICY];
            nxt_state.card_supply_request = reg_wdata[SFPC_CB_VCC_LO +: 3];
            nxt_state.programming_supply_request = reg_wdata[SFPC_CB_VPP_LO +: 3];
            if (!supply_ok(reg_wdata[SFPC_CB_VCC_LO +: 3], 1'b0, state_ff.present, state_ff.auto_power_en) ||
                !supply_ok(reg_wdata[SFPC_CB_VPP_LO +: 3], 1'b1, state_ff.present, state_ff.auto_power_en)) begin
                nxt_state.present.invalid_supply_request_flag = 1'b1;
            end
        end

        // card supply applied only for legal codes
        // and, under automatic control, only at voltages the cardbus card accepts
        nxt_state.vcc_apply = supply_ok(state_ff.card_supply_request, 1'b0, state_ff.present,
                                        state_ff.auto_power_en) ? state_ff.card_supply_request : SFPC_SUP_OFF;
        // programming supply legal codes include 12 V
        nxt_state.vpp_apply = supply_ok(state_ff.programming_supply_request, 1'b1, state_ff.present,
                                        state_ff.auto_power_en) ? state_ff.programming_supply_request
                                                                : SFPC_SUP_OFF;
        // powered flag follows the supply, never the force write
        nxt_state.present.socket_powered_flag = (state_ff.vcc_apply != SFPC_SUP_OFF);

        // read data valid in the cycle after the strobe only
        // force register reads zero
        // force bits read back as zero, nothing relies on them
        nxt_state.rdata = '0;
        if (reg_rd) begin
            if (reg_addr == SFPC_OFS_CONTROL) begin
                nxt_state.rdata = control_word;
            end else if (reg_addr == SFPC_OFS_STATUS) begin
                nxt_state.rdata = status_word;
            end else begin
                nxt_state.rdata = '0;
            end
        end

        // bus reset always clears policy and re-enables automatic control; supply fields and flags only without power events
        if (bus_reset) begin
            nxt_state.clock_halt_policy = 1'b0;
            nxt_state.auto_power_en = 1'b1;
            nxt_state.phase = SFPC_IDLE;
            nxt_state.probe_cnt = '0;
            nxt_state.rdata = '0;
            if (!pme_enable) begin
                nxt_state.card_supply_request = SFPC_SUP_OFF;
                nxt_state.programming_supply_request = SFPC_SUP_OFF;
                nxt_state.vcc_apply = SFPC_SUP_OFF;
                nxt_state.vpp_apply = SFPC_SUP_OFF;
                nxt_state.present = STATE_RESET.present;
            end
        end
    end

    // ======================================================================
    // state register
    // ======================================================================
    // global reset loads the control reset value
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= STATE_RESET;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    // ======================================================================
    // outputs
    // ======================================================================
    // event force is a one-cycle pulse beside the write strobe
    assign event_force_strobe = wr_force && clk_en;
    // detect events written; live levels untouched
    // status event written; live level untouched
    assign event_force_value = '{power_event_flag: reg_wdata[SFPC_FB_POWER],
                                 detect_two_event_flag: reg_wdata[SFPC_FB_DETECT2],
                                 detect_one_event_flag: reg_wdata[SFPC_FB_DETECT1],
                                 status_change_event_flag: reg_wdata[SFPC_FB_STATUS]};

    // policy one stops regardless of host clock run
    assign card_clk_stop_req = card_idle && (state_ff.clock_halt_policy || host_clkrun_stopping);

    assign reg_rdata = state_ff.rdata;
    assign present_flags = state_ff.present;
    assign vcc_apply = state_ff.vcc_apply;
    assign vpp_apply = state_ff.vpp_apply;
    assign auto_power_en = state_ff.auto_power_en;
    assign probe_busy = (state_ff.phase == SFPC_PROBE);

endmodule

// *** sfpc_monitor.sv ***
`timescale 1ns/1ns
// ==========================================
// port checker of the socket force and supply block
module sfpc_monitor
    import sfpc_pkg::*;
#(
    parameter int PROBE_CYCLES = SFPC_PROBE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic bus_reset,
    input wire logic pme_enable,
    input wire logic [SFPC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire sfpc_pins_t card_pins,
    input wire logic host_clkrun_stopping,
    input wire logic card_idle,
    input wire logic card_clk_stop_req,
    input wire sfpc_present_t present_flags,
    input wire logic event_force_strobe,
    input wire sfpc_event_t event_force_value,
    input wire logic [2:0] vcc_apply,
    input wire logic [2:0] vpp_apply,
    input wire logic auto_power_en,
    input wire logic probe_busy
);
    localparam int PROBE_MAX = PROBE_CYCLES + 4;
    logic force_wr;
    // force write that bus reset does not override
    assign force_wr = reg_wr && clk_en && !bus_reset && reg_addr == SFPC_OFS_FORCE;
    default clocking mon_cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    // ==========================================
    // assertions
    strobe_pulse_a: assert property (event_force_strobe == (reg_wr && clk_en && reg_addr == SFPC_OFS_FORCE))
        else $error("force strobe does not follow the force write");
    event_value_a: assert property (event_force_strobe |-> event_force_value == reg_wdata[3:0])
        else $error("forced event value differs from write data");
    clock_stop_a: assert property (!card_idle || host_clkrun_stopping |-> card_clk_stop_req == card_idle)
        else $error("card clock stop request wrong");
    force_read_a: assert property ($past(reg_rd && clk_en && reg_addr == SFPC_OFS_FORCE) |-> reg_rdata == 32'h0)
        else $error("force register read not zero");
    control_read_a: assert property ($past(reg_rd && clk_en && !bus_reset && reg_addr == SFPC_OFS_CONTROL)
        |-> reg_rdata[31:8] == 24'h000004 && !reg_rdata[3]) else $error("control reserved bits wrong");
    force_flags_a: assert property ($past(force_wr && !probe_busy && !reg_wdata[SFPC_FB_RETEST])
        |-> present_flags[12:4] == $past({reg_wdata[13:7], reg_wdata[5:4]})) else $error("forced flags not written");
    auto_off_a: assert property ($past(force_wr && |reg_wdata[13:10] && !reg_wdata[14]) |-> !auto_power_en)
        else $error("automatic power control still on");
    retest_start_a: assert property ($past(force_wr && reg_wdata[SFPC_FB_RETEST]) |-> probe_busy && auto_power_en)
        else $error("retest did not start interrogation");
    probe_len_a: assert property ($rose(probe_busy) |-> ##[1:PROBE_MAX] !probe_busy)
        else $error("interrogation too long");
    detect_hold_a: assert property (probe_busy && $past(probe_busy) && !$past(bus_reset)
        |-> $stable(present_flags[2:1])) else $error("detect levels moved during interrogation");
    powered_a: assert property ($past(clk_en && !bus_reset)
        |-> present_flags.socket_powered_flag == ($past(vcc_apply) != 3'h0)) else $error("powered flag wrong");
endmodule
bind sfpc_top sfpc_monitor #(.PROBE_CYCLES(PROBE_CYCLES)) i_monitor (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .clk_en(clk_en), .bus_reset(bus_reset), .pme_enable(pme_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .card_pins(card_pins),
    .host_clkrun_stopping(host_clkrun_stopping), .card_idle(card_idle), .card_clk_stop_req(card_clk_stop_req),
    .present_flags(present_flags), .event_force_strobe(event_force_strobe), .event_force_value(event_force_value),
    .vcc_apply(vcc_apply), .vpp_apply(vpp_apply), .auto_power_en(auto_power_en), .probe_busy(probe_busy));

// *** sfpc_top_tb.sv ***
`timescale 1ns/1ns
// ==========================================
// self-checking bench of the socket force and supply block
module sfpc_top_tb
    import sfpc_pkg::*;
;
    logic clk_sys = 1'b0;
    logic sys_rst, clk_en, bus_reset, pme_enable, reg_wr, reg_rd, host_clkrun_stopping, card_idle;
    logic card_clk_stop_req, event_force_strobe, auto_power_en, probe_busy, rd_prev, p;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [2:0] vcc_apply, vpp_apply, c, m_vcc, m_vpp;
    logic [12:0] m_pf;
    logic m_auto;
    sfpc_pins_t card_pins;
    sfpc_present_t present_flags;
    sfpc_event_t event_force_value;
    logic [31:0] exp_q[$];
    logic [31:0] mask_q[$];
    string name_q[$];
    int failures = 0;
    int samples_checked = 0;
    sfpc_top #(.PROBE_CYCLES(4)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
        .bus_reset(bus_reset), .pme_enable(pme_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .card_pins(card_pins),
        .host_clkrun_stopping(host_clkrun_stopping), .card_idle(card_idle), .card_clk_stop_req(card_clk_stop_req),
        .present_flags(present_flags), .event_force_strobe(event_force_strobe),
        .event_force_value(event_force_value), .vcc_apply(vcc_apply), .vpp_apply(vpp_apply),
        .auto_power_en(auto_power_en), .probe_busy(probe_busy));
    // clock generation
    always #5 clk_sys = ~clk_sys;
    // ==========================================
    // bus tasks and comparison
    task automatic check_word(input string n, input logic [31:0] e, input logic [31:0] k, input logic [31:0] g);
        samples_checked++;
        if ((g & k) !== (e & k)) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e & k, g & k);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k, input string n);
        exp_q.push_back(e);
        mask_q.push_back(k);
        name_q.push_back(n);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask
    // wait for the interrogation to finish, bounded
    task automatic settle();
        int n;
        for (n = 0; n < 60 && (n < 10 || probe_busy !== 1'b0); n++) begin
            @(posedge clk_sys);
        end
        if (n == 60) begin
            failures++;
        end
    endtask
    function automatic logic [31:0] status_word();
        return {8'h00, m_vpp, m_vcc, 1'b0, m_auto, 3'h0, m_pf};
    endfunction
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // read result watcher: oldest note against the data in the cycle after the strobe
    always @(negedge clk_sys) begin
        if (rd_prev && exp_q.size() > 0) begin
            check_word(name_q.pop_front(), exp_q.pop_front(), mask_q.pop_front(), reg_rdata);
        end
        rd_prev = reg_rd;
    end
    // watchdog
    initial begin
        #50000;
        failures++;
        finish_test();
    end
    // ==========================================
    // main sequence
    initial begin
        {sys_rst, clk_en, bus_reset, pme_enable, reg_wr, reg_rd, rd_prev} = 7'h61;
        {host_clkrun_stopping, card_idle, reg_addr, reg_wdata} = '0;
        card_pins = 10'h300;
        void'($urandom(38));
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        {m_pf, m_auto, m_vcc, m_vpp} = {13'h0006, 1'b1, 6'h00};
        rd(SFPC_OFS_CONTROL, SFPC_CONTROL_RESET, '1, "control reset");
        rd(SFPC_OFS_FORCE, 32'h0, '1, "force read");
        rd(8'h40, 32'h0, '1, "unmapped read");
        rd(SFPC_OFS_STATUS, status_word(), 32'h00FF_FFFF, "status reset");
        // forced flags and events, with live levels left alone
        for (int i = 0; i < 10; i++) begin
            d = (i == 0) ? 32'hFFFF_BFBF : ($urandom & 32'h0000_3FBF);
            wr(SFPC_OFS_FORCE, d);
            m_pf[12:4] = {d[13:7], d[5:4]};
            m_auto = m_auto & ~|d[13:10];
            rd(SFPC_OFS_STATUS, status_word(), 32'h00FF_FFFF, "status after force");
        end
        // card insertion, then retest reloads flags and re-enables power control
        card_pins <= 10'h043;
        settle();
        wr(SFPC_OFS_FORCE, 32'h0000_4000);
        settle();
        {m_pf, m_auto} = {13'h0620, 1'b1};
        rd(SFPC_OFS_STATUS, status_word(), 32'h00FF_FFFF, "status after retest");
        // every supply code, with random clock stop inputs
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            p = $urandom % 2;
            host_clkrun_stopping <= $urandom % 2;
            card_idle <= $urandom % 2;
            d = {24'h0, p, c, 1'b0, c};
            wr(SFPC_OFS_CONTROL, d);
            m_vcc = (c == 3'h0 || (c >= 3'h2 && c <= 3'h5 && m_pf[7 + c])) ? c : 3'h0;
            m_vpp = (c <= 3'h1 || (c <= 3'h5 && m_pf[7 + c])) ? c : 3'h0;
            m_pf[3] = m_vcc != 3'h0;
            m_pf[8] = m_pf[8] | (m_vcc != c) | (m_vpp != c);
            repeat (3) @(posedge clk_sys);
            rd(SFPC_OFS_CONTROL, 32'h400 | d, '1, "control back");
            rd(SFPC_OFS_STATUS, status_word(), 32'h00FF_FFFF, "status supply");
            check_word("clock stop", {31'h0, card_idle & (p | host_clkrun_stopping)}, 32'h1, {31'h0, card_clk_stop_req});
        end
        // forced capability turns off automatic control, so any legal code is applied
        wr(SFPC_OFS_FORCE, 32'h0000_1020);
        wr(SFPC_OFS_CONTROL, 32'h0000_0050);
        // a write while the clock enable is low must leave every flag alone
        clk_en <= 1'b0;
        wr(SFPC_OFS_FORCE, '0);
        clk_en <= 1'b1;
        {m_pf[12:4], m_auto, m_vcc} = {9'h082, 1'b0, 3'h5};
        repeat (3) @(posedge clk_sys);
        m_pf[3] = 1'b1;
        rd(SFPC_OFS_STATUS, status_word(), 32'h00FF_FFFF, "status forced caps");
        // bus reset keeps supply fields only while power events are enabled
        // it re-enables automatic control, so the unaccepted y supply drops
        {m_auto, m_vcc, m_pf[3]} = {1'b1, 3'h0, 1'b0};
        for (int i = 0; i < 2; i++) begin
            pme_enable <= (i == 0);
            @(posedge clk_sys);
            bus_reset <= 1'b1;
            @(posedge clk_sys);
            bus_reset <= 1'b0;
            repeat (2) @(posedge clk_sys);
            rd(SFPC_OFS_CONTROL, (i == 0) ? 32'h450 : 32'h400, '1, "control after bus reset");
            rd(SFPC_OFS_STATUS, (i == 0) ? status_word() : 32'h0001_0000, 32'h00FF_FFFF,
                "status after bus reset");
        end
        repeat (3) @(posedge clk_sys);
        finish_test();
    end
endmodule
